/* File: rtl/acr_pkg.sv */
// Package: register map, field layout and decode tables for the three config registers
package acr_pkg;
   localparam logic [7:0] ADDR_RATE_CFG = 8'h01;
   localparam logic [7:0] ADDR_FLAG_CFG = 8'h02;
   localparam logic [7:0] ADDR_ROUTE_CFG = 8'h03;
   localparam logic [7:0] RST_RATE_CFG = 8'h00;
   localparam logic [7:0] RST_FLAG_CFG = 8'h00;
   localparam logic [7:0] RST_ROUTE_CFG = 8'h00;
   // First register fields
   localparam int RATE_HI = 7;
   localparam int RATE_LO = 5;
   localparam int SPEED_BIT = 4;
   localparam int REPEAT_BIT = 3;
   localparam int REF_HI = 2;
   localparam int REF_LO = 1;
   localparam int TEMP_BIT = 0;
   // Second register fields
   localparam int READY_BIT = 7;
   localparam int COUNT_BIT = 6;
   localparam int CHECK_HI = 5;
   localparam int CHECK_LO = 4;
   localparam int BURN_BIT = 3;
   localparam int EXC_HI = 2;
   localparam int EXC_LO = 0;
   // Third register: bit 1 reads zero
   localparam logic [7:0] ROUTE_WMASK = 8'hfd;
   localparam logic [2:0] RATE_RESERVED = 3'h7;
   localparam logic [1:0] CHECK_RESERVED = 2'h3;
   localparam logic [1:0] REF_INTERNAL = 2'h0;
   localparam logic [1:0] REF_EXTERNAL = 2'h1;
   // Modulator clock rates
   localparam int CLK_KHZ = 25000;
   localparam int MOD_NORMAL_KHZ = 256;
   localparam int MOD_TURBO_KHZ = 512;
   localparam int MOD_NORMAL_DIV = CLK_KHZ / MOD_NORMAL_KHZ;
   localparam int MOD_TURBO_DIV = CLK_KHZ / MOD_TURBO_KHZ;
   typedef enum logic [1:0] {
      ACR_REF_INT = 2'b00,
      ACR_REF_EXT = 2'b01,
      ACR_REF_SUP = 2'b10
   } acr_ref_e;
   typedef enum logic [1:0] {
      ACR_CHK_NONE = 2'b00,
      ACR_CHK_INV = 2'b01,
      ACR_CHK_CRC = 2'b10,
      ACR_CHK_RSV = 2'b11
   } acr_check_e;
   // Samples per second for a rate code in normal mode; turbo doubles the figure
   function automatic logic [11:0] acr_rate_sps(input logic [2:0] code, input logic turbo);
      logic [11:0] base;
      base = 12'h000;
      case (code)
         3'h0: base = 12'd20;
         3'h1: base = 12'd45;
         3'h2: base = 12'd90;
         3'h3: base = 12'd175;
         3'h4: base = 12'd330;
         3'h5: base = 12'd600;
         3'h6: base = 12'd1000;
         default: base = 12'h000;
      endcase
      acr_rate_sps = turbo ? {base[10:0], 1'b0} : base;
   endfunction : acr_rate_sps
   // Excitation magnitude in microamperes
   function automatic logic [10:0] acr_exc_ua(input logic [2:0] code);
      case (code)
         3'h1: acr_exc_ua = 11'd10;
         3'h2: acr_exc_ua = 11'd50;
         3'h3: acr_exc_ua = 11'd100;
         3'h4: acr_exc_ua = 11'd250;
         3'h5: acr_exc_ua = 11'd500;
         3'h6: acr_exc_ua = 11'd1000;
         3'h7: acr_exc_ua = 11'd1500;
         default: acr_exc_ua = 11'd0;
      endcase
   endfunction : acr_exc_ua
endpackage : acr_pkg

/* File: rtl/acr_mod_tick.sv */
// Modulator clock enable divider for normal and turbo speed
`timescale 1ns/10ps
`default_nettype none
module acr_mod_tick #(
   parameter int NORMAL_DIV = acr_pkg::MOD_NORMAL_DIV,
   parameter int TURBO_DIV = acr_pkg::MOD_TURBO_DIV
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic turbo,
   output logic tick
);
   import acr_pkg::*;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic [7:0] limit;
   logic at_end;
   // Integer divide leaves the rate slightly fast; fine for a status tick
   assign limit = turbo ? 8'(TURBO_DIV - 1) : 8'(NORMAL_DIV - 1);
   assign at_end = (cnt_q >= limit);
   assign cnt_d = at_end ? 8'h00 : cnt_q + 8'h01;
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 8'h00;
         tick <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick <= at_end;
      end
   end
endmodule : acr_mod_tick
`default_nettype wire

/* File: rtl/acr_ready_flag.sv */
// Sticky result-ready flag; a new result wins over a clearing read
`timescale 1ns/10ps
`default_nettype none
module acr_ready_flag (
   input wire logic clk,
   input wire logic rst,
   input wire logic set,
   input wire logic clear,
   output logic flag
);
   always_ff @(posedge clk) begin
      if (rst) begin
         flag <= 1'b0;
      end else if (set) begin
         flag <= 1'b1;
      end else if (clear) begin
         flag <= 1'b0;
      end
   end
endmodule : acr_ready_flag
`default_nettype wire

/* File: rtl/acr_regs.sv */
// Three configuration registers: rate/conversion, flags/excitation and routing
// Contract
// - Bits 7:5 of the first register select the data rate, whose meaning depends on speed; 111 is reserved.
// - Speed bit clear runs the modulator at 256 kHz with rates 20 to 1000 samples per second.
// - Speed bit set runs the modulator at 512 kHz with rates 40 to 2000 samples per second.
// - Bit 3 of the first register selects single-shot (0, default) or continuous (1) conversion.
// - Bits 2:1 select the reference: 00 internal, 01 external pins, 10 and 11 analog supply.
// - Bit 0 set measures the temperature sensor on the internal reference, ignoring register zero.
// - Bit 7 of the second register is a read-only result-ready flag, zero at reset.
// - Reading the conversion data clears the result-ready flag.
// - Bit 6 of the second register enables the conversion data counter, off by default.
// - Bits 5:4 select integrity check: none, inverted copy, CRC16, 11 reserved.
// - Bit 3 of the second register switches the 10 uA burn-out sources, off by default.
// - Bits 2:0 set the magnitude of both excitation sources, 000 meaning off.
// - The second register sits at 02h and resets to zero.
// - The third register sits at 03h and resets to zero.
// - The first register sits at 01h and resets to zero.
`timescale 1ns/10ps
`default_nettype none
module acr_regs (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic result_done,
   input wire logic data_read,
   output logic mod_tick,
   output logic [2:0] sample_rate_sel,
   output logic [11:0] sample_rate_sps,
   output logic turbo_en,
   output logic conversion_repeat_sel,
   output acr_pkg::acr_ref_e ref_sel,
   output logic temp_sensor_en,
   output logic mux_cfg_ignore,
   output logic result_ready_flag,
   output logic conversion_counter_en,
   output acr_pkg::acr_check_e check_sel,
   output logic burnout_source_en,
   output logic [2:0] excitation_magnitude_sel,
   output logic [10:0] excitation_ua,
   output logic [7:0] route_cfg,
   output logic rsv_code_seen
);
   import acr_pkg::*;

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [7:0] rate_cfg_q;
   logic [7:0] flag_cfg_q;
   logic [7:0] route_cfg_q;
   logic [7:0] rdata_d;
   logic hit_rate;
   logic hit_flag;
   logic hit_route;
   logic ready_raw;
   logic [2:0] rate_code;
   logic [1:0] ref_code;
   logic [1:0] chk_code;
   logic rsv_d;

   assign hit_rate = (reg_addr == ADDR_RATE_CFG);
   assign hit_flag = (reg_addr == ADDR_FLAG_CFG);
   assign hit_route = (reg_addr == ADDR_ROUTE_CFG);

   // ----------------------------------------
   // Writes
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         rate_cfg_q <= RST_RATE_CFG;
         flag_cfg_q <= RST_FLAG_CFG;
         route_cfg_q <= RST_ROUTE_CFG;
      end else if (reg_wr) begin
         if (hit_rate) begin
            rate_cfg_q <= reg_wdata;
         end
         if (hit_flag) begin
            flag_cfg_q <= {1'b0, reg_wdata[COUNT_BIT:EXC_LO]};
         end
         if (hit_route) begin
            route_cfg_q <= reg_wdata & ROUTE_WMASK;
         end
      end
   end

   // ----------------------------------------
   // Result-ready flag
   // ----------------------------------------
   // clear on data read
   acr_ready_flag u_ready (
      .clk(clk),
      .rst(rst),
      .set(result_done),
      .clear(data_read),
      .flag(ready_raw)
   );

   // ----------------------------------------
   // Modulator tick
   // ----------------------------------------
   // normal or turbo speed tick, chosen by the speed bit
   acr_mod_tick u_tick (
      .clk(clk),
      .rst(rst),
      .turbo(rate_cfg_q[SPEED_BIT]),
      .tick(mod_tick)
   );

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   // rate selector
   assign rate_code = rate_cfg_q[RATE_HI:RATE_LO];
   // reference select, temp mode forces internal
   assign ref_code = rate_cfg_q[TEMP_BIT] ? REF_INTERNAL : rate_cfg_q[REF_HI:REF_LO];
   assign chk_code = flag_cfg_q[CHECK_HI:CHECK_LO];
   // flag reserved codes left by the host
   assign rsv_d = (rate_code == RATE_RESERVED) || (chk_code == CHECK_RESERVED);

   // second register read at 02h, flag in bit 7
   assign rdata_d = hit_rate ? rate_cfg_q :
                    hit_flag ? {ready_raw, flag_cfg_q[COUNT_BIT:EXC_LO]} :
                    hit_route ? route_cfg_q : 8'h00;

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
         sample_rate_sel <= 3'h0;
         sample_rate_sps <= 12'h000;
         turbo_en <= 1'b0;
         conversion_repeat_sel <= 1'b0;
         ref_sel <= ACR_REF_INT;
         temp_sensor_en <= 1'b0;
         mux_cfg_ignore <= 1'b0;
         result_ready_flag <= 1'b0;
         conversion_counter_en <= 1'b0;
         check_sel <= ACR_CHK_NONE;
         burnout_source_en <= 1'b0;
         excitation_magnitude_sel <= 3'h0;
         excitation_ua <= 11'h000;
         route_cfg <= 8'h00;
         rsv_code_seen <= 1'b0;
      end else begin
         // Read data held between reads so a slow host sees a stable byte
         if (reg_rd) begin
            reg_rdata <= rdata_d;
         end
         sample_rate_sel <= rate_code;
         sample_rate_sps <= acr_rate_sps(rate_code, rate_cfg_q[SPEED_BIT]);
         turbo_en <= rate_cfg_q[SPEED_BIT];
         conversion_repeat_sel <= rate_cfg_q[REPEAT_BIT];
         // codes 10 and 11 both mean supply
         ref_sel <= ref_code[1] ? ACR_REF_SUP : acr_ref_e'(ref_code);
         temp_sensor_en <= rate_cfg_q[TEMP_BIT];
         mux_cfg_ignore <= rate_cfg_q[TEMP_BIT];
         result_ready_flag <= ready_raw;
         conversion_counter_en <= flag_cfg_q[COUNT_BIT];
         check_sel <= acr_check_e'(chk_code);
         burnout_source_en <= flag_cfg_q[BURN_BIT];
         excitation_magnitude_sel <= flag_cfg_q[EXC_HI:EXC_LO];
         excitation_ua <= acr_exc_ua(flag_cfg_q[EXC_HI:EXC_LO]);
         route_cfg <= route_cfg_q;
         rsv_code_seen <= rsv_d;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   flag_set_wins_a: assert property (@(posedge clk) disable iff (rst)
      result_done |=> ready_raw)
      else $error("ready flag missed a new result");

   flag_clear_a: assert property (@(posedge clk) disable iff (rst)
      (data_read && !result_done) |=> !ready_raw)
      else $error("ready flag not cleared by data read");

   flag_ro_a: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && hit_flag && !result_done && !ready_raw) |=> !ready_raw)
      else $error("ready flag changed by a write");

   rate_write_a: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && hit_rate) |=> ##1 (sample_rate_sel == $past(reg_wdata[RATE_HI:RATE_LO], 2)))
      else $error("rate selector not taken from write");

   turbo_rate_a: assert property (@(posedge clk) disable iff (rst)
      (rate_cfg_q[SPEED_BIT] && rate_code == 3'h6) |=> (sample_rate_sps == 12'd2000))
      else $error("turbo top rate wrong");

   normal_rate_a: assert property (@(posedge clk) disable iff (rst)
      (!rate_cfg_q[SPEED_BIT] && rate_code == 3'h0) |=> (sample_rate_sps == 12'd20))
      else $error("normal base rate wrong");

   temp_ref_a: assert property (@(posedge clk) disable iff (rst)
      rate_cfg_q[TEMP_BIT] |=> (ref_sel == ACR_REF_INT && mux_cfg_ignore))
      else $error("temperature mode not on internal reference");

   supply_ref_a: assert property (@(posedge clk) disable iff (rst)
      (!rate_cfg_q[TEMP_BIT] && rate_cfg_q[REF_HI]) |=> (ref_sel == ACR_REF_SUP))
      else $error("supply reference decode wrong");

   exc_max_a: assert property (@(posedge clk) disable iff (rst)
      (flag_cfg_q[EXC_HI:EXC_LO] == 3'h7) |=> (excitation_ua == 11'd1500))
      else $error("excitation top code wrong");

   route_read_a: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && hit_route) |=> (reg_rdata[1] == 1'b0))
      else $error("routing reserved bit reads one");

   count_en_a: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && hit_flag) |=> ##1 (conversion_counter_en == $past(reg_wdata[COUNT_BIT], 2)))
      else $error("counter enable not taken from write");

   burn_a: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && hit_flag) |=> ##1 (burnout_source_en == $past(reg_wdata[BURN_BIT], 2)))
      else $error("burn-out enable not taken from write");

   mode_a: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && hit_rate) |=> ##1 (conversion_repeat_sel == $past(reg_wdata[REPEAT_BIT], 2)))
      else $error("conversion mode not taken from write");

   check_a: assert property (@(posedge clk) disable iff (rst)
      (chk_code == CHECK_RESERVED) |=> (rsv_code_seen && check_sel == ACR_CHK_RSV))
      else $error("reserved check code not reported");

   rsv_rate_a: assert property (@(posedge clk) disable iff (rst)
      (rate_code == RATE_RESERVED) |=> (rsv_code_seen && sample_rate_sps == 12'h000))
      else $error("reserved rate code not reported");

   flag_read_a: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && hit_flag) |=> (reg_rdata[READY_BIT] == $past(ready_raw)))
      else $error("ready flag not read in bit 7");

   // Reset checks carry no disable so the release edge itself is covered
   rate_reset_a: assert property (@(posedge clk)
      $fell(rst) |-> (rate_cfg_q == RST_RATE_CFG))
      else $error("first register not cleared by reset");

   flag_reset_a: assert property (@(posedge clk)
      $fell(rst) |-> (flag_cfg_q == RST_FLAG_CFG))
      else $error("second register not cleared by reset");

   route_reset_a: assert property (@(posedge clk)
      $fell(rst) |-> (route_cfg_q == RST_ROUTE_CFG))
      else $error("third register not cleared by reset");

   ready_reset_a: assert property (@(posedge clk)
      $fell(rst) |-> (!ready_raw && !result_ready_flag))
      else $error("ready flag not cleared by reset");

   exc_off_a: assert property (@(posedge clk) disable iff (rst)
      (flag_cfg_q[EXC_HI:EXC_LO] == 3'h0) |=> (excitation_ua == 11'h000))
      else $error("excitation not off for code zero");

   ext_ref_a: assert property (@(posedge clk) disable iff (rst)
      (!rate_cfg_q[TEMP_BIT] && rate_cfg_q[REF_HI:REF_LO] == REF_EXTERNAL)
      |=> (ref_sel == ACR_REF_EXT))
      else $error("external reference decode wrong");

   int_ref_a: assert property (@(posedge clk) disable iff (rst)
      (rate_cfg_q[REF_HI:REF_LO] == REF_INTERNAL) |=> (ref_sel == ACR_REF_INT))
      else $error("internal reference decode wrong");

   normal_top_a: assert property (@(posedge clk) disable iff (rst)
      (!rate_cfg_q[SPEED_BIT] && rate_code == 3'h6) |=> (sample_rate_sps == 12'h3e8))
      else $error("normal top rate wrong");

   turbo_base_a: assert property (@(posedge clk) disable iff (rst)
      (rate_cfg_q[SPEED_BIT] && rate_code == 3'h0) |=> (sample_rate_sps == 12'h028))
      else $error("turbo base rate wrong");

   tick_pulse_a: assert property (@(posedge clk) disable iff (rst)
      mod_tick |=> !mod_tick)
      else $error("modulator tick longer than one cycle");

   rsv_clear_a: assert property (@(posedge clk) disable iff (rst)
      (rate_code != RATE_RESERVED && chk_code != CHECK_RESERVED) |=> !rsv_code_seen)
      else $error("reserved code reported without cause");
endmodule : acr_regs
`default_nettype wire

/* File: bench/acr_host_model.sv */
// Far-side model: conversion-complete and data-fetch events seen by the three config registers
`timescale 1ns/10ps
`default_nettype none
module acr_host_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic conv_go,
   input wire logic data_go,
   output logic result_done,
   output logic data_read
);
   // ----------------------------------------
   // Event pulses
   // ----------------------------------------
   // one-cycle events
   // Registered so both pulses launch just after an edge, never mid-cycle
   always_ff @(posedge clk) begin
      result_done <= conv_go & ~rst;
      data_read <= data_go & ~rst;
   end
endmodule : acr_host_model
`default_nettype wire

/* File: bench/acr_regs_tb.sv */
// Self-checking bench for the three configuration registers
`timescale 1ns/10ps
`default_nettype none
module acr_regs_tb;
   import acr_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_rd = 1'b0;
   logic conv_go = 1'b0;
   logic data_go = 1'b0;
   logic [7:0] reg_rdata, route_cfg;
   logic result_done, data_read, mod_tick, turbo_en, conversion_repeat_sel;
   logic temp_sensor_en, mux_cfg_ignore, result_ready_flag, conversion_counter_en;
   logic burnout_source_en, rsv_code_seen;
   logic [2:0] sample_rate_sel, excitation_magnitude_sel;
   logic [11:0] sample_rate_sps;
   logic [10:0] excitation_ua;
   acr_ref_e ref_sel;
   acr_check_e check_sel;
   int fail_count = 0;
   int total_checks = 0;
   logic [11:0] sps_n [8] = '{12'd20, 12'd45, 12'd90, 12'd175, 12'd330, 12'd600, 12'd1000, 12'd0};
   logic [11:0] sps_t [8] = '{12'd40, 12'd90, 12'd180, 12'd350, 12'd660, 12'd1200, 12'd2000, 12'd0};
   logic [10:0] exc [8] = '{11'd0, 11'd10, 11'd50, 11'd100, 11'd250, 11'd500, 11'd1000, 11'd1500};
   logic [7:0] d;
   logic [1:0] r;
   initial begin
      forever #20 clk = ~clk;
   end
   acr_regs i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .result_done(result_done), .data_read(data_read), .mod_tick(mod_tick),
      .sample_rate_sel(sample_rate_sel), .sample_rate_sps(sample_rate_sps),
      .turbo_en(turbo_en), .conversion_repeat_sel(conversion_repeat_sel),
      .ref_sel(ref_sel), .temp_sensor_en(temp_sensor_en), .mux_cfg_ignore(mux_cfg_ignore),
      .result_ready_flag(result_ready_flag), .conversion_counter_en(conversion_counter_en),
      .check_sel(check_sel), .burnout_source_en(burnout_source_en),
      .excitation_magnitude_sel(excitation_magnitude_sel), .excitation_ua(excitation_ua),
      .route_cfg(route_cfg), .rsv_code_seen(rsv_code_seen));
   acr_host_model i_host (.clk(clk), .rst(rst), .conv_go(conv_go), .data_go(data_go),
      .result_done(result_done), .data_read(data_read));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Decoded outputs settle one edge after the write is taken
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      #1;
   endtask : rd
   // Flag output trails the event by three edges
   task automatic ev(input logic c, input logic f);
      @(posedge clk);
      conv_go <= c;
      data_go <= f;
      @(posedge clk);
      conv_go <= 1'b0;
      data_go <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask : ev
   // First gap after a speed change may be partial, so only the second counts
   task automatic tick_gap(input logic [11:0] exp);
      int n;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge clk);
            #1;
            n++;
         end while (mod_tick !== 1'b1 && n < 300);
         if (n >= 300) begin
            fail_count++;
            wrap_up();
         end
      end
      chk(12'(n), exp);
   endtask : tick_gap
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int a = 1; a < 4; a++) begin
         rd(8'(a));
         chk(reg_rdata, 8'h00); // reset value
      end
      for (int t = 0; t < 2; t++) begin
         for (int c = 0; c < 8; c++) begin
            d = {3'(c), t[0], 4'h0};
            wr(ADDR_RATE_CFG, d);
            chk(sample_rate_sel, d[7:5]); // rate field
            chk(turbo_en, t[0]); // speed bit
            chk(sample_rate_sps, t[0] ? sps_t[c] : sps_n[c]); // rate table
            chk(rsv_code_seen, c == 7); // reserved code reported
            rd(ADDR_RATE_CFG);
            chk(reg_rdata, d); // read back
         end
      end
      for (int i = 0; i < 4; i++) begin
         r = 2'(i);
         wr(ADDR_RATE_CFG, {4'h0, r[0], r, 1'b0});
         chk(conversion_repeat_sel, r[0]); // conversion mode
         chk(ref_sel, r[1] ? 2'h2 : r); // reference select
         chk(temp_sensor_en, 1'b0); // sensor off
      end
      wr(ADDR_RATE_CFG, 8'h03);
      chk(ref_sel, REF_INTERNAL); // internal reference
      chk(temp_sensor_en, 1'b1); // sensor on
      chk(mux_cfg_ignore, 1'b1); // mux ignored
      wr(ADDR_RATE_CFG, 8'h00);
      tick_gap(12'd97); // normal tick spacing
      wr(ADDR_RATE_CFG, 8'h10);
      tick_gap(12'd48); // turbo tick spacing
      // second register fields, flag bit read only
      for (int i = 0; i < 8; i++) begin
         d = {1'b1, i[0], i[1:0], i[1], i[2:0]};
         wr(ADDR_FLAG_CFG, d);
         chk(conversion_counter_en, i[0]); // counter enable
         chk(check_sel, i[1:0]); // check select
         chk(rsv_code_seen, i[1:0] == 2'h3); // reserved code reported
         chk(burnout_source_en, i[1]); // burn-out sources
         chk(excitation_magnitude_sel, i[2:0]); // magnitude field
         chk(excitation_ua, exc[i]); // magnitude value
         rd(ADDR_FLAG_CFG);
         chk(reg_rdata, {1'b0, d[6:0]}); // flag not writable
      end
      // flag set, clear, set beats clear
      ev(1'b1, 1'b0);
      chk(result_ready_flag, 1'b1); // flag set
      rd(ADDR_FLAG_CFG);
      chk(reg_rdata[7], 1'b1); // flag readable
      ev(1'b0, 1'b1);
      chk(result_ready_flag, 1'b0); // cleared by data read
      rd(ADDR_FLAG_CFG);
      chk(reg_rdata[7], 1'b0); // cleared in register
      ev(1'b1, 1'b1);
      chk(result_ready_flag, 1'b1); // new result wins
      wr(ADDR_ROUTE_CFG, 8'hff);
      rd(ADDR_ROUTE_CFG);
      chk(reg_rdata, 8'hfd); // bit one reads zero
      chk(route_cfg, 8'hfd); // exported copy
      wr(8'h05, 8'hff);
      wr(8'h00, 8'hff);
      rd(8'h05);
      chk(reg_rdata, 8'h00); // unmapped reads zero
      rd(ADDR_RATE_CFG);
      chk(reg_rdata, 8'h10); // first register untouched
      // second reset clears written registers and the flag
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk(result_ready_flag, 1'b0); // flag cleared by reset
      for (int a = 1; a < 4; a++) begin
         rd(8'(a));
         chk(reg_rdata, 8'h00); // value after second reset
      end
      wrap_up();
   end
endmodule : acr_regs_tb
`default_nettype wire
